// File: include/acmode_pkg.sv
// shared constants for the accelerometer operating mode controller
package acmode_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  // apb register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_SAMPLE = 8'h0c;
  localparam logic [7:0] REG_SENSOR = 8'h10;
  // ctrl fields
  localparam int MODE_LSB = 0;
  localparam int AUTO_MEAS_BIT = 2;
  localparam int AUTO_IRQ_BIT = 3;
  localparam int AUTO_WAKE_BIT = 4;
  localparam int SYNC_EN_BIT = 5;
  localparam int EXTCLK_EN_BIT = 6;
  localparam int IRQ_CLR_BIT = 7;
  // cfg fields
  localparam int RANGE_LSB = 0;
  localparam int RATE_LSB = 2;
  localparam int CORNER_BIT = 5;
  localparam int SAMPLE_W = 12;
  localparam logic [1:0] RANGE_RST = 2'h0;
  localparam logic [2:0] RATE_RST = 3'h3;
  localparam logic CORNER_RST = 1'b0;
  localparam logic [2:0] RATE_MAX = 3'h5;
  localparam logic [1:0] RANGE_MAX = 2'h2;
  // wake-up sampling rate, about six per second
  localparam int unsigned WAKE_HZ = 6;
  localparam int unsigned WAKE_CYC = CLK_HZ / WAKE_HZ;
  // 12.5 Hz base period in clocks; higher rates halve it
  localparam int unsigned BASE_RATE_MHZ = 12500;
  localparam int unsigned BASE_CYC = CLK_HZ / BASE_RATE_MHZ * 1000;
  localparam int unsigned SETTLE_PERIODS = 4;
  localparam logic [11:0] MOTION_THR = 12'h0c8;
  typedef enum logic [1:0] {
    ACM_STANDBY = 2'b00,
    ACM_MEASURE = 2'b10,
    ACM_WAKEUP = 2'b11
  } acm_mode_t;
endpackage

// File: logic/acmode_core.sv
// operating mode controller: standby, measurement and wake-up sampling with apb access
// Overview of operation
// - measurement samples continuously; wake-up mode samples slowly for activity only.
// - host can select standby, which suspends all measurement.
// - measurement mode yields data continuously; activity timer works.
// - measurement samples every rate period, never duty cycled.
// - wake-up mode samples about six times per second for motion.
// - motion in wake-up may switch the device into measurement mode.
// - motion in wake-up may raise an interrupt to the host.
// - motion in wake-up may drive an output powering downstream circuitry.
// - activity duration timer is disabled in wake-up mode.
// - in wake-up all registers stay accessible and samples readable.
// - entering standby keeps pending interrupts and held data.
// - standby generates no new interrupt.
// - after reset the device sits in standby with sensing off.
// - three ranges, always 12-bit results; step weight follows range.
// - overrange may clip reported values; reporting recovers afterwards.
// - output rates from 12.5 Hz up to 400 Hz.
// - filter corner is quarter or half of output rate.
// - sync mode turns second interrupt pin into a sample trigger input.
// - external clock mode turns first interrupt pin into a clock input.
// - after reset the filter corner is a quarter of the rate.
// - first valid data within four rate periods of entering measurement.
`timescale 1ns/10ps
module acmode_core
  import acmode_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = WAKE_CYC,
  parameter int unsigned BASE_CYCLES = BASE_CYC,
  parameter int unsigned ACT_SAMPLES = 3
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] sensor_in,
  input wire logic irq_out_a_ext_clk_in_i,
  output logic irq_out_a_ext_clk_in_o,
  output logic irq_out_a_ext_clk_in_oe,
  input wire logic irq_out_b_sync_in_i,
  output logic irq_out_b_sync_in_o,
  output logic irq_out_b_sync_in_oe,
  output logic wake_out,
  output logic [11:0] sample_out,
  output logic sample_valid,
  output logic [1:0] filter_corner_code
);
  import acmode_pkg::*;

  acm_mode_t mode_r;
  logic auto_meas_r, auto_irq_r, auto_wake_r, sync_en_r, extclk_en_r;
  logic [1:0] range_r;
  logic [2:0] rate_r;
  logic filter_corner_select_r;
  logic irq_pend_r, motion_r, data_ready_r, settled_r;
  logic [11:0] sample_r;
  logic [31:0] tick_cnt_r;
  logic [2:0] settle_cnt_r;
  logic [3:0] act_cnt_r;
  logic ext_clk_s1_r, ext_clk_s2_r, ext_clk_d_r;
  logic sync_s1_r, sync_s2_r, sync_d_r;

  // scale a raw sample to 12 bits for the selected range, saturating on overrange
  function automatic logic [11:0] scale_sample(input logic [15:0] raw, input logic [1:0] rng);
    logic signed [15:0] s;
    logic signed [15:0] sh;
    s = signed'(raw);
    sh = s >>> (2'd2 - rng);
    if (sh > 16'sd2047)
      return 12'h7ff;
    else if (sh < -16'sd2048)
      return 12'h800;
    else
      return sh[11:0];
  endfunction

  function automatic logic [11:0] mag12(input logic [11:0] v);
    return v[11] ? 12'((~v) + 12'h001) : v;
  endfunction

  wire logic apb_wr = psel && penable && pwrite;
  wire logic apb_rd_setup = psel && !penable && !pwrite;
  wire logic [31:0] rate_period = 32'(BASE_CYCLES) >> rate_r;
  wire logic [31:0] period = (mode_r == ACM_WAKEUP) ? 32'(WAKE_CYCLES) : rate_period;

  // pin samplers; first stage is read only by the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ext_clk_s1_r <= 1'b0;
      ext_clk_s2_r <= 1'b0;
      ext_clk_d_r <= 1'b0;
      sync_s1_r <= 1'b0;
      sync_s2_r <= 1'b0;
      sync_d_r <= 1'b0;
    end
    else
    begin
      ext_clk_s1_r <= irq_out_a_ext_clk_in_i;
      ext_clk_s2_r <= ext_clk_s1_r;
      ext_clk_d_r <= ext_clk_s2_r;
      sync_s1_r <= irq_out_b_sync_in_i;
      sync_s2_r <= sync_s1_r;
      sync_d_r <= sync_s2_r;
    end
  end

  // external clock edges stand in for the internal tick
  wire logic tick_src = extclk_en_r ? (ext_clk_s2_r && !ext_clk_d_r) : 1'b1;
  wire logic sync_edge = sync_s2_r && !sync_d_r;

  // rate divider; standby holds it so no samples are taken
  logic tick_done;
  assign tick_done = tick_src && (tick_cnt_r + 32'h1 >= period);
  always_ff @(posedge clk)
  begin
    if (rst || mode_r == ACM_STANDBY)
      tick_cnt_r <= 32'h0;
    else if (tick_done)
      tick_cnt_r <= 32'h0;
    else if (tick_src)
      tick_cnt_r <= tick_cnt_r + 32'h1;
  end

  // sync mode: samples are timed by the trigger pin, not the divider
  logic take;
  assign take = (mode_r != ACM_STANDBY) && (sync_en_r ? sync_edge : tick_done);

  // sample capture, settling count and motion detection
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sample_r <= 12'h000;
      settle_cnt_r <= 3'h0;
      settled_r <= 1'b0;
      data_ready_r <= 1'b0;
      act_cnt_r <= 4'h0;
      motion_r <= 1'b0;
    end
    else if (mode_r == ACM_STANDBY)
    begin
      settle_cnt_r <= 3'h0; // held data is kept
      settled_r <= 1'b0;
      motion_r <= 1'b0;
      act_cnt_r <= 4'h0;
    end
    else if (take)
    begin
      sample_r <= scale_sample(sensor_in, range_r);
      if (!settled_r)
      begin
        settle_cnt_r <= settle_cnt_r + 3'h1;
        if (settle_cnt_r + 3'h1 >= 3'(SETTLE_PERIODS) - 3'h1)
          settled_r <= 1'b1;
      end
      data_ready_r <= settled_r || data_ready_r;
      if (mag12(scale_sample(sensor_in, range_r)) > MOTION_THR)
      begin
        // wake-up mode has no duration timer: one sample is enough
        if (mode_r == ACM_WAKEUP)
          motion_r <= 1'b1;
        else if (act_cnt_r + 4'h1 >= 4'(ACT_SAMPLES))
          motion_r <= 1'b1;
        else
          act_cnt_r <= act_cnt_r + 4'h1;
      end
      else
      begin
        act_cnt_r <= 4'h0;
        motion_r <= 1'b0;
      end
    end
  end
  wire logic wake_motion = (mode_r == ACM_WAKEUP) && motion_r && settled_r;

  // control register, mode changes effective immediately
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_r <= ACM_STANDBY;
      auto_meas_r <= 1'b0;
      auto_irq_r <= 1'b0;
      auto_wake_r <= 1'b0;
      sync_en_r <= 1'b0;
      extclk_en_r <= 1'b0;
    end
    else if (apb_wr && paddr == REG_CTRL)
    begin
      case (pwdata[MODE_LSB +: 2])
        2'b10: mode_r <= ACM_MEASURE;
        2'b11: mode_r <= ACM_WAKEUP;
        default: mode_r <= ACM_STANDBY;
      endcase
      auto_meas_r <= pwdata[AUTO_MEAS_BIT];
      auto_irq_r <= pwdata[AUTO_IRQ_BIT];
      auto_wake_r <= pwdata[AUTO_WAKE_BIT];
      sync_en_r <= pwdata[SYNC_EN_BIT];
      extclk_en_r <= pwdata[EXTCLK_EN_BIT];
    end
    else if (wake_motion && auto_meas_r)
      mode_r <= ACM_MEASURE;
  end

  // configuration register, retained through standby
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      range_r <= RANGE_RST;
      rate_r <= RATE_RST;
      filter_corner_select_r <= CORNER_RST;
    end
    else if (apb_wr && paddr == REG_CFG)
    begin
      if (pwdata[RANGE_LSB +: 2] <= RANGE_MAX)
        range_r <= pwdata[RANGE_LSB +: 2];
      if (pwdata[RATE_LSB +: 3] <= RATE_MAX)
        rate_r <= pwdata[RATE_LSB +: 3];
      filter_corner_select_r <= pwdata[CORNER_BIT];
    end
  end

  // interrupt pending: set wins over clear; standby raises none
  wire logic irq_clr = apb_wr && paddr == REG_CTRL && pwdata[IRQ_CLR_BIT];
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_pend_r <= 1'b0;
    else if (wake_motion && auto_irq_r && mode_r != ACM_STANDBY)
      irq_pend_r <= 1'b1;
    else if (irq_clr)
      irq_pend_r <= 1'b0; // standby alone never clears it
  end

  // pin drivers and stream outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_out_a_ext_clk_in_o <= 1'b0;
      irq_out_a_ext_clk_in_oe <= 1'b0;
      irq_out_b_sync_in_o <= 1'b0;
      irq_out_b_sync_in_oe <= 1'b0;
      wake_out <= 1'b0;
      sample_out <= 12'h000;
      sample_valid <= 1'b0;
      filter_corner_code <= 2'h0;
    end
    else
    begin
      irq_out_a_ext_clk_in_o <= irq_pend_r;
      irq_out_a_ext_clk_in_oe <= !extclk_en_r;
      irq_out_b_sync_in_o <= irq_pend_r;
      irq_out_b_sync_in_oe <= !sync_en_r;
      if (mode_r == ACM_WAKEUP && auto_wake_r && motion_r && settled_r)
        wake_out <= 1'b1;
      else if (mode_r == ACM_STANDBY)
        wake_out <= 1'b0;
      sample_out <= sample_r;
      sample_valid <= take && settled_r;
      // 1: corner at half the rate, 0: quarter
      filter_corner_code <= {1'b1, filter_corner_select_r};
    end
  end

  // apb slave: zero wait states, reads captured in setup phase
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == REG_CTRL || paddr == REG_CFG ||
        paddr == REG_STATUS || paddr == REG_SAMPLE || paddr == REG_SENSOR);
      if (apb_rd_setup)
      begin
        case (paddr)
          REG_CTRL: prdata <= {24'h0, 1'b0, extclk_en_r, sync_en_r, auto_wake_r, auto_irq_r,
            auto_meas_r, mode_r};
          REG_CFG: prdata <= {26'h0, filter_corner_select_r, rate_r, range_r};
          REG_STATUS: prdata <= {26'h0, wake_out, settled_r, data_ready_r, motion_r, irq_pend_r,
            mode_r != ACM_STANDBY};
          REG_SAMPLE: prdata <= {20'h0, sample_r};
          REG_SENSOR: prdata <= {16'h0, sensor_in};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule // acmode_core

// File: testbench/acmode_props.sv
// concurrent checks on the operating mode controller ports
`timescale 1ns/10ps
module acmode_props
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq_out_a_ext_clk_in_o,
  input wire logic irq_out_a_ext_clk_in_oe,
  input wire logic irq_out_b_sync_in_o,
  input wire logic irq_out_b_sync_in_oe,
  input wire logic wake_out,
  input wire logic sample_valid,
  input wire logic [1:0] filter_corner_code
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_ready_answer: assert property (psel && !penable |=> pready)
    else $error("no answer one cycle after setup");
  chk_ready_access: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("ready outside an access phase");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  chk_slverr_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  chk_corner_fixed: assert property (!$past(rst) |-> filter_corner_code[1])
    else $error("corner code upper bit low");
  chk_irq_pins_agree: assert property (irq_out_a_ext_clk_in_oe && irq_out_b_sync_in_oe
    |-> irq_out_a_ext_clk_in_o == irq_out_b_sync_in_o) else $error("interrupt pins disagree");
  chk_reset_quiet: assert property (disable iff (1'b0) $past(rst)
    |-> !wake_out && !sample_valid && !pready && !irq_out_a_ext_clk_in_o) else $error("output active after reset");
  chk_valid_pulse: assert property (sample_valid |=> !sample_valid)
    else $error("sample valid longer than one cycle");
endmodule // acmode_props

// File: testbench/acmode_host.sv
// host model: apb master for register transfers
`timescale 1ns/10ps
module acmode_host
(
  input wire logic clk,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [7:0] paddr = 8'h00,
  output logic [31:0] pwdata = 32'h0,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; // select held through the whole transfer
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // stale data must not look valid after release
    pwdata <= ~d;
    if (pready !== 1'b1)
    begin
      tb_top.err_count++;
      tb_top.conclude();
    end
  endtask
endmodule // acmode_host

// File: testbench/tb_top.sv
// self-checking bench for the operating mode controller
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
  import acmode_pkg::*;
  localparam int BASE = 64;
  localparam int WAKE = 50;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, ext_clk, sync_lvl, err, a_o, a_oe, b_o, b_oe, wk, sv, cr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, pre;
  logic [15:0] sensor_in;
  logic [11:0] sample_out;
  logic [1:0] fcc;
  // wire level: pin driven by the core when enabled, else by the outside party
  wire a_pin = a_oe ? a_o : ext_clk;
  wire b_pin = b_oe ? b_o : sync_lvl;
  int err_count = 0, tests_run = 0, vcnt = 0, seed, n, v0, p, i, rg;
  acmode_core #(.WAKE_CYCLES(WAKE), .BASE_CYCLES(BASE)) acmode_core_i (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sensor_in(sensor_in), .irq_out_a_ext_clk_in_i(a_pin), .irq_out_a_ext_clk_in_o(a_o),
    .irq_out_a_ext_clk_in_oe(a_oe), .irq_out_b_sync_in_i(b_pin), .irq_out_b_sync_in_o(b_o),
    .irq_out_b_sync_in_oe(b_oe), .wake_out(wk), .sample_out(sample_out), .sample_valid(sv),
    .filter_corner_code(fcc));
  acmode_host acmode_host_i (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // external clock runs free, phase unrelated to clk
  initial
  begin
    ext_clk = 1'b0;
    #7;
    forever #80 ext_clk = ~ext_clk;
  end
  always @(posedge clk) if (sv === 1'b1) vcnt <= vcnt + 1;
  function automatic logic [31:0] cfgw(int r, int t, logic c);
    return 32'(r) | (32'(t) << RATE_LSB) | (32'(c) << CORNER_BIT);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    acmode_host_i.xfer(1'b1, a, d, x, e);
  endtask
  task automatic rd(input logic [7:0] a);
    acmode_host_i.xfer(1'b0, a, 32'h0, q, err);
  endtask
  task automatic wv(input int lim);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (sv !== 1'b1 && n < lim);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    seed = 32'h14b4;
    rst = 1'b1;
    sensor_in = 16'h0;
    sync_lvl = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("corner_code", 2'b10, fcc)
    rd(REG_CFG);
    `CHK("cfg_reset", cfgw(RANGE_RST, RATE_RST, CORNER_RST), q)
    rd(REG_CTRL);
    `CHK("ctrl_reset", 32'h0, q)
    rd(8'h14);
    `CHK("unmapped", 33'h100000000, {err, q})
    wv(300);
    `CHK("standby_idle", 300, n)
    for (i = 0; i <= 5; i++)
    begin
      p = BASE >> i;
      rg = {$random(seed)} % 3;
      cr = 1'($random(seed));
      sensor_in <= 16'($random(seed)) & 16'h00ff;
      wr(REG_CFG, cfgw(rg, i, cr));
      rd(REG_CFG);
      `CHK("cfg_rw", cfgw(rg, i, cr), q)
      `CHK("corner", {1'b1, cr}, fcc)
      wr(REG_CTRL, 32'h2);
      wv(4 * p + 4);
      `CHK("first_data", 1'b1, n <= 4 * p + 2)
      wv(p + 4);
      `CHK("rate_period", p, n)
      wr(REG_CTRL, 32'h0);
    end
    wr(REG_CFG, cfgw(3, 7, 1'b0));
    rd(REG_CFG);
    `CHK("cfg_refused", cfgw(rg, 5, 1'b0), q)
    wr(REG_CFG, cfgw(0, 3, 1'b0));
    sensor_in <= 16'h0;
    wr(REG_CTRL, 32'h3);
    rd(REG_CTRL);
    `CHK("mode_wake", 2'b11, q[1:0])
    wv(4 * WAKE + 4);
    wv(WAKE + 4);
    `CHK("wake_period", WAKE, n)
    sensor_in <= 16'h4000;
    wr(REG_CTRL, 32'h1f);
    n = 0;
    while (wk !== 1'b1 && n < 8 * WAKE)
    begin
      @(posedge clk);
      n++;
    end
    // interrupt pin follows one cycle after the wake output
    repeat (2) @(posedge clk);
    `CHK("wake_out", 1'b1, wk)
    `CHK("irq_wake", 1'b1, a_o)
    rd(REG_CTRL);
    `CHK("auto_measure", 2'b10, q[1:0])
    wr(REG_CTRL, 32'h0);
    rd(REG_SAMPLE);
    pre = q;
    `CHK("sample_reg", 12'h7ff, pre[11:0])
    `CHK("sample_clip", 12'h7ff, sample_out)
    repeat (100) @(posedge clk);
    rd(REG_SAMPLE);
    `CHK("sample_kept", pre, q)
    `CHK("irq_kept", 1'b1, a_o)
    // clear while auto-irq stays armed, still in standby
    wr(REG_CTRL, 32'h88);
    repeat (300) @(posedge clk);
    `CHK("no_new_irq", 1'b0, a_o)
    wr(REG_CFG, cfgw(0, 0, 1'b0));
    wr(REG_CTRL, 32'h22);
    repeat (2) @(posedge clk);
    `CHK("sync_pin_in", 1'b0, b_oe)
    wv(300);
    v0 = vcnt;
    repeat (8)
    begin
      sync_lvl <= 1'b1; // sample triggers from the outside party
      repeat (5) @(posedge clk);
      sync_lvl <= 1'b0;
      repeat (5) @(posedge clk);
    end
    // three settling samples, then five valid ones
    `CHK("sync_samples", 5, vcnt - v0)
    wr(REG_CFG, cfgw(0, 5, 1'b0));
    wr(REG_CTRL, 32'h42);
    repeat (2) @(posedge clk);
    `CHK("ext_pin_in", 1'b0, a_oe)
    wv(300);
    wv(40);
    `CHK("ext_period", 1'b1, n >= 15 && n <= 17)
    conclude();
  end
endmodule // tb_top
bind acmode_core acmode_props acmode_props_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .irq_out_a_ext_clk_in_o(irq_out_a_ext_clk_in_o),
  .irq_out_a_ext_clk_in_oe(irq_out_a_ext_clk_in_oe), .irq_out_b_sync_in_o(irq_out_b_sync_in_o),
  .irq_out_b_sync_in_oe(irq_out_b_sync_in_oe), .wake_out(wake_out), .sample_valid(sample_valid),
  .filter_corner_code(filter_corner_code));
